/* File: verilog/adc_seq_pkg.sv */
// constants shared by the converter control logic and its result formatter
package adc_seq_pkg;

  // serial transfer shape
  localparam int unsigned WORD_BITS  = 16;              // bits shifted out per transfer
  localparam int unsigned CTRL_BITS  = 12;              // leading input bits loaded as control
  localparam int unsigned DATA_BITS  = 12;              // widest result field
  localparam int unsigned RAW_BITS   = 13;              // front-end code over twice the reference
  localparam logic [4:0]  LAST_FALL  = 5'h0F;           // count value at the final clock fall

  // control word bit positions
  localparam int unsigned WRITE_POS  = 11;
  localparam int unsigned SEQ_HI_POS = 10;
  localparam int unsigned ADDR_HI_POS = 7;
  localparam int unsigned ADDR_LO_POS = 6;
  localparam int unsigned PM_HI_POS  = 5;
  localparam int unsigned PM_LO_POS  = 4;
  localparam int unsigned SEQ_LO_POS = 3;
  localparam int unsigned RANGE_POS  = 1;
  localparam int unsigned CODING_POS = 0;

  // sequence-mode codes {seq_mode_hi, seq_mode_lo}
  localparam logic [1:0]  SEQ_KEEP   = 2'h2;            // leaves a running sequence alone
  localparam logic [1:0]  SEQ_START  = 2'h3;            // programs ascending sequence

  // values after reset
  localparam logic [11:0] CTRL_RESET = 12'h030;         // normal power, channel 0, binary
  localparam logic [1:0]  CHAN_RESET = 2'h0;
  localparam logic [1:0]  SYNC_RESET = 2'h3;            // sync stages idle high
  localparam logic [12:0] FULL_12    = 13'h0FFF;        // largest code of a 12-bit field

  typedef enum logic [1:0] {
    st_idle,
    st_shift,
    st_wait
  } xfer_state_t;

endpackage : adc_seq_pkg

/* File: verilog/result_format.sv */
// result formatter: range, coding and 16-bit output word packing
module result_format #(
  parameter int unsigned RES = 12
) (
  input  wire logic [12:0] raw_code,
  input  wire logic        range_ref,
  input  wire logic        twos_sel,
  input  wire logic [1:0]  chan,
  output logic      [15:0] word
);

  localparam logic [11:0] KEEP_MASK = 12'hFFF << (12 - RES);

  logic [11:0] span_code;
  logic [11:0] coded;

  // range scales the code, coding flips the top bit, trailing bits are cleared
  always_comb begin
    if (range_ref) begin
      span_code = (raw_code > adc_seq_pkg::FULL_12) ? 12'hFFF : raw_code[11:0];
    end else begin
      span_code = raw_code[12:1];   // one step is twice as wide over the doubled span
    end
    coded = twos_sel ? {~span_code[11], span_code[10:0]} : span_code; // mid-span maps to zero
    word  = {2'h0, chan, coded & KEEP_MASK};
  end

endmodule : result_format

/* File: verilog/adc_seq_ctrl.sv */
// serial control, channel sequencer and result output of a four-channel converter
module adc_seq_ctrl #(
  parameter int unsigned RES = 12
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic [12:0] conv_raw,
  output logic             dout,
  output logic             dout_oe,
  output logic [1:0]       mux_chan,
  output logic             sample_hold,
  output logic             range_ref,
  output logic [1:0]       power_mode,
  output logic             seq_active
);

  logic [2:0]                  sync1_reg;
  logic [2:0]                  sync2_reg;
  logic [2:0]                  sync3_reg;
  logic [2:0]                  filt_reg;
  logic [2:0]                  prev_reg;
  adc_seq_pkg::xfer_state_t    state_reg;
  logic [4:0]                  bit_cnt_reg;
  logic [11:0]                 shift_in_reg;
  logic [15:0]                 word_reg;
  logic [15:0]                 word_next;
  logic [11:0]                 ctrl_reg;
  logic                        seq_active_reg;
  logic [1:0]                  seq_ptr_reg;
  logic [1:0]                  seq_last_reg;
  logic                        conv_seq_reg;
  logic [1:0]                  mux_chan_reg;
  logic                        dout_reg;
  logic                        dout_oe_reg;
  logic                        cs_fall;
  logic                        cs_rise;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic                        din_f;
  logic                        xfer_done;
  logic                        wr_now;
  logic [1:0]                  seq_code;
  logic [1:0]                  ctrl_addr;
  logic                        shift_take;
  logic [3:0]                  in_cnt_reg;

  // three-stage synchronisers; a level is accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          sync1_reg[gi] <= adc_seq_pkg::SYNC_RESET[0];
          sync2_reg[gi] <= adc_seq_pkg::SYNC_RESET[0];
          sync3_reg[gi] <= adc_seq_pkg::SYNC_RESET[0];
          filt_reg[gi]  <= adc_seq_pkg::SYNC_RESET[0];
          prev_reg[gi]  <= adc_seq_pkg::SYNC_RESET[0];
        end else begin
          sync1_reg[gi] <= (gi == 0) ? cs_n : ((gi == 1) ? sclk : din);
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
          prev_reg[gi] <= filt_reg[gi];
        end
      end
    end
  endgenerate

  // edge detection on the filtered levels
  assign cs_fall   = prev_reg[0] & ~filt_reg[0];
  assign cs_rise   = ~prev_reg[0] & filt_reg[0];
  assign sclk_rise = ~prev_reg[1] & filt_reg[1];
  assign sclk_fall = prev_reg[1] & ~filt_reg[1];
  assign din_f     = filt_reg[2];

  assign xfer_done = (state_reg == adc_seq_pkg::st_shift) && !cs_rise && sclk_fall
                     && (bit_cnt_reg == adc_seq_pkg::LAST_FALL);
  assign wr_now    = xfer_done && shift_in_reg[adc_seq_pkg::WRITE_POS];
  assign seq_code  = {shift_in_reg[adc_seq_pkg::SEQ_HI_POS],
                      shift_in_reg[adc_seq_pkg::SEQ_LO_POS]};
  assign ctrl_addr = {ctrl_reg[adc_seq_pkg::ADDR_HI_POS], ctrl_reg[adc_seq_pkg::ADDR_LO_POS]};

  // a control bit is taken on the rise that follows each of the first twelve falls
  assign shift_take = (state_reg == adc_seq_pkg::st_shift) && !cs_rise && sclk_rise
                      && (bit_cnt_reg >= 5'h01)
                      && (bit_cnt_reg <= 5'(adc_seq_pkg::CTRL_BITS));

  // result word from the current range and coding settings
  result_format #(
    .RES(RES)
  ) u_fmt (
    .raw_code (conv_raw),
    .range_ref(ctrl_reg[adc_seq_pkg::RANGE_POS]),
    .twos_sel (ctrl_reg[adc_seq_pkg::CODING_POS]),
    .chan     (mux_chan_reg),
    .word     (word_next)
  );

  // transfer sequencing: bit counting, input shifting and output shifting
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg    <= adc_seq_pkg::st_idle;
      bit_cnt_reg  <= 5'h00;
      shift_in_reg <= 12'h000;
      word_reg     <= 16'h0000;
      dout_reg     <= 1'b0;
      dout_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        adc_seq_pkg::st_idle: begin
          if (cs_fall) begin
            state_reg   <= adc_seq_pkg::st_shift;
            bit_cnt_reg <= 5'h00;
            dout_reg    <= 1'b0;          // first leading zero
            dout_oe_reg <= 1'b1;
          end
        end
        adc_seq_pkg::st_shift: begin
          if (cs_rise) begin
            state_reg   <= adc_seq_pkg::st_idle;   // aborted transfer loads nothing
            dout_oe_reg <= 1'b0;
          end else begin
            if (shift_take) begin
              shift_in_reg <= {shift_in_reg[10:0], din_f};   // msb first
            end
            if (sclk_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == 5'h00) begin
                word_reg <= word_next;    // result taken at the first clock fall
                dout_reg <= 1'b0;         // second leading zero
              end else if (bit_cnt_reg == adc_seq_pkg::LAST_FALL) begin
                state_reg   <= adc_seq_pkg::st_wait;
                dout_oe_reg <= 1'b0;
                dout_reg    <= 1'b0;
              end else begin
                dout_reg <= word_reg[4'(5'h0E - bit_cnt_reg)];  // MSB first
              end
            end
          end
        end
        adc_seq_pkg::st_wait: begin
          if (cs_rise) begin
            state_reg <= adc_seq_pkg::st_idle;
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::st_idle;
        end
      endcase
    end
  end

  // control register loads only on completed transfers with the write flag set
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_reg <= adc_seq_pkg::CTRL_RESET;
    end else if (wr_now) begin
      ctrl_reg <= shift_in_reg;
    end
  end

  // channel chosen at the start of a conversion
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mux_chan_reg <= adc_seq_pkg::CHAN_RESET;
      conv_seq_reg <= 1'b0;
    end else if (state_reg == adc_seq_pkg::st_idle && cs_fall) begin
      conv_seq_reg <= seq_active_reg;
      if (seq_active_reg) begin
        mux_chan_reg <= seq_ptr_reg;
      end else begin
        mux_chan_reg <= ctrl_addr;        // binary index
      end
    end
  end

  // sequencer: start, stop, step and wrap at the end of each transfer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      seq_active_reg <= 1'b0;
      seq_ptr_reg    <= adc_seq_pkg::CHAN_RESET;
      seq_last_reg   <= adc_seq_pkg::CHAN_RESET;
    end else if (xfer_done) begin
      if (wr_now && seq_code == adc_seq_pkg::SEQ_START) begin
        seq_active_reg <= 1'b1;
        seq_ptr_reg    <= 2'h0;
        seq_last_reg   <= {shift_in_reg[adc_seq_pkg::ADDR_HI_POS],
                           shift_in_reg[adc_seq_pkg::ADDR_LO_POS]};
      end else if (wr_now && seq_code != adc_seq_pkg::SEQ_KEEP) begin
        seq_active_reg <= 1'b0;
      end else if (seq_active_reg && conv_seq_reg) begin
        if (seq_ptr_reg == seq_last_reg) begin
          seq_ptr_reg <= 2'h0;
        end else begin
          seq_ptr_reg <= seq_ptr_reg + 2'h1;
        end
      end
    end
  end

  // helper for the checks below: control bits taken in the current frame
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      in_cnt_reg <= 4'h0;
    end else if (state_reg == adc_seq_pkg::st_idle) begin
      in_cnt_reg <= 4'h0;
    end else if (shift_take) begin
      in_cnt_reg <= in_cnt_reg + 4'h1;
    end
  end

  assign dout        = dout_reg;
  assign dout_oe     = dout_oe_reg;
  assign mux_chan    = mux_chan_reg;
  assign sample_hold = dout_oe_reg;
  assign range_ref   = ctrl_reg[adc_seq_pkg::RANGE_POS];
  assign power_mode  = {ctrl_reg[adc_seq_pkg::PM_HI_POS], ctrl_reg[adc_seq_pkg::PM_LO_POS]};
  assign seq_active  = seq_active_reg;

  // checks on the control and sequencing behaviour
  a_ctrl_write_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_now |=> ctrl_reg == $past(shift_in_reg))
    else $error("control register did not load on write");

  a_ctrl_no_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (xfer_done && !shift_in_reg[adc_seq_pkg::WRITE_POS]) |=> $stable(ctrl_reg))
    else $error("control register changed without write flag");

  a_seq_start_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_now && seq_code == adc_seq_pkg::SEQ_START) |=> seq_active_reg && seq_ptr_reg == 2'h0)
    else $error("sequence did not start at channel 0");

  a_seq_stop_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_now && seq_code != adc_seq_pkg::SEQ_KEEP && seq_code != adc_seq_pkg::SEQ_START)
    |=> !seq_active_reg)
    else $error("sequence not ended by terminating write");

  a_seq_wrap_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (xfer_done && !wr_now && seq_active_reg && conv_seq_reg && seq_ptr_reg == seq_last_reg)
    |=> seq_ptr_reg == 2'h0 && seq_active_reg)
    else $error("sequence did not wrap to channel 0");

  a_seq_step_one: assert property (@(posedge ref_clk) disable iff (!resetn)
    (xfer_done && !wr_now && seq_active_reg && conv_seq_reg && seq_ptr_reg != seq_last_reg)
    |=> seq_ptr_reg == $past(seq_ptr_reg) + 2'h1)
    else $error("sequence pointer did not step by one");

  a_manual_chan_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == adc_seq_pkg::st_idle && cs_fall && !seq_active_reg)
    |=> mux_chan_reg == $past(ctrl_addr))
    else $error("manual channel differs from address bits");

  a_word_chan_tag: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == adc_seq_pkg::st_shift && bit_cnt_reg != 5'h00)
    |-> word_reg[13:12] == mux_chan_reg && word_reg[15:14] == 2'h0)
    else $error("output word address differs from converted channel");

  a_lead_zero_out: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == adc_seq_pkg::st_idle && cs_fall) |=> dout_oe_reg && !dout_reg)
    else $error("transfer did not open with a driven zero");

  a_ctrl_bit_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    xfer_done |-> in_cnt_reg == 4'(adc_seq_pkg::CTRL_BITS))
    else $error("control word did not take exactly twelve bits");

  a_seq_chan_ptr: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == adc_seq_pkg::st_idle && cs_fall && seq_active_reg)
    |=> mux_chan_reg == $past(seq_ptr_reg) && conv_seq_reg)
    else $error("sequenced conversion used a channel other than the pointer");

  a_oe_drop_end: assert property (@(posedge ref_clk) disable iff (!resetn)
    xfer_done |=> !dout_oe_reg && state_reg == adc_seq_pkg::st_wait)
    else $error("output stayed enabled after the last clock fall");

  a_abort_no_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == adc_seq_pkg::st_shift && cs_rise)
    |=> $stable(ctrl_reg) && $stable(seq_active_reg) && $stable(seq_ptr_reg))
    else $error("cut frame changed control or sequencer state");

  a_seq_hold_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!seq_active_reg && !(wr_now && seq_code == adc_seq_pkg::SEQ_START))
    |=> !seq_active_reg)
    else $error("sequencer started without a start code");

endmodule : adc_seq_ctrl

/* File: verif/host_model.sv */
// host side model: drives serial frames and captures the returned words
module host_model (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ns;

  // link idles with select high and clock high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // one frame of nfall clocks; control bits go out msb first on the first 12 falls
  task automatic xfer(input logic [11:0] ctrl, input int nfall, output logic [15:0] word);
    @(negedge ref_clk);
    cs_n = 1'b0;
    #400;
    for (int k = 0; k < nfall; k++) begin
      word[15-k] = dout;                       // bit settled since the previous fall
      sclk       = 1'b0;
      din        = (k < 12) ? ctrl[11-k] : 1'b0;
      #200;
      sclk = 1'b1;
      #200;
    end
    cs_n = 1'b1;
    din  = ~din;                               // released line does not keep its level
    #400;
  endtask : xfer
endmodule : host_model

/* File: verif/tb_adc_seq_ctrl.sv */
// testbench of the converter control block with a host model on the link
module tb_adc_seq_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RES = 10;
  logic        ref_clk     = 1'b0;
  logic        resetn      = 1'b0;
  logic [12:0] conv_raw    = 13'h0000;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        sample_hold;
  logic        range_ref;
  logic        seq_active;
  logic [1:0]  mux_chan;
  logic [1:0]  power_mode;
  logic [15:0] word;
  int          bad_count   = 0;
  int          comparisons = 0;

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

  adc_seq_ctrl #(.RES(RES)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din),
    .conv_raw(conv_raw), .dout(dout), .dout_oe(dout_oe), .mux_chan(mux_chan),
    .sample_hold(sample_hold), .range_ref(range_ref), .power_mode(power_mode),
    .seq_active(seq_active)
  );

  // control word: write, seq_hi, 2 spare, address, normal power, seq_lo, spare, range, coding
  function automatic logic [11:0] mk(input logic wr, input logic [1:0] sq, input logic [1:0] ch,
                                     input logic rng, input logic cod);
    return {wr, sq[1], 2'h0, ch, 2'h3, sq[0], 1'b0, rng, cod};
  endfunction : mk

  // expected output word worked out from range, coding and resolution
  function automatic logic [15:0] exp_word(input logic [1:0] ch, input logic [12:0] raw,
                                           input logic rng, input logic cod);
    logic [11:0] code;
    code     = rng ? ((raw > 13'h0FFF) ? 12'hFFF : raw[11:0]) : raw[12:1];
    code[11] = code[11] ^ cod;
    code     = code & ~((12'h001 << (12 - RES)) - 12'h001);
    return {2'h0, ch, code};
  endfunction : exp_word

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic go(input logic [11:0] ctrl, input logic [12:0] raw, input int n = 16);
    @(negedge ref_clk);
    conv_raw = raw;
    host.xfer(ctrl, n, word);
  endtask : go

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // each channel in manual mode with its own range and coding pair, covering all four pairs
  task automatic t_manual();
    logic [12:0] raws [4] = '{13'h0000, 13'h1FFF, 13'h1000, 13'h0ABC};
    logic [1:0]  ch;
    for (int i = 0; i < 4; i++) begin
      ch = 2'(i);
      go(mk(1'b1, 2'h0, ch, ch[0], ch[1]), 13'h0000);
      check(16'(range_ref), 16'(ch[0]));
      go(mk(1'b0, 2'h0, ~ch, ~ch[0], ~ch[1]), raws[i]);
      check(word, exp_word(ch, raws[i], ch[0], ch[1]));
      if (i == 2) begin
        check(word, 16'h2000);
      end
      check(16'(mux_chan), 16'(ch));
      check(16'(dout_oe), 16'h0000);
      check(16'(sample_hold), 16'h0000);
    end
  endtask : t_manual

  // ascending sequence to channel 2, a keep write, then an ending write
  task automatic t_sequence();
    go(mk(1'b1, adc_seq_pkg::SEQ_START, 2'h2, 1'b1, 1'b0), 13'h0123);
    check(16'(seq_active), 16'h0001);
    for (int i = 0; i < 9; i++) begin
      go(mk(i == 6, (i == 6) ? adc_seq_pkg::SEQ_KEEP : 2'h0, 2'h3, 1'b1, 1'b0),
         13'h0123);
      check(word, exp_word(2'(i % 3), 13'h0123, 1'b1, 1'b0));
    end
    check(16'(seq_active), 16'h0001);
    go(mk(1'b1, 2'h1, 2'h1, 1'b1, 1'b0), 13'h0123);
    check(word, exp_word(2'h0, 13'h0123, 1'b1, 1'b0));
    check(16'(seq_active), 16'h0000);
    go(mk(1'b0, 2'h0, 2'h3, 1'b1, 1'b0), 13'h0123);
    check(word, exp_word(2'h1, 13'h0123, 1'b1, 1'b0));
  endtask : t_sequence

  // a frame cut short after 13 clocks must not load the control bits
  task automatic t_abort();
    go(mk(1'b1, 2'h0, 2'h2, 1'b1, 1'b0), 13'h0055);
    go(mk(1'b1, 2'h0, 2'h3, 1'b0, 1'b1), 13'h0055, 13);
    check(16'(range_ref), 16'h0001);
    go(mk(1'b0, 2'h0, 2'h0, 1'b0, 1'b0), 13'h0055);
    check(word, exp_word(2'h2, 13'h0055, 1'b1, 1'b0));
  endtask : t_abort

  // host parks the converter in shutdown between bursts and wakes it again
  task automatic t_power();
    go(mk(1'b1, 2'h0, 2'h1, 1'b0, 1'b1) ^ 12'h010, 13'h1000);
    check(16'(power_mode), 16'h0002);
    fork
      go(mk(1'b0, 2'h0, 2'h3, 1'b1, 1'b0), 13'h1000);
      begin
        #3000;
        check(16'(dout_oe), 16'h0001);
        check(16'(sample_hold), 16'h0001);
      end
    join
    check(word, 16'h1000);
    check(16'(power_mode), 16'h0002);
    go(mk(1'b1, 2'h0, 2'h1, 1'b0, 1'b1), 13'h1000);
    check(16'(power_mode), 16'h0003);
  endtask : t_power

  // reset in the middle of a running sequence returns to manual operation
  task automatic t_reset();
    go(mk(1'b1, adc_seq_pkg::SEQ_START, 2'h3, 1'b1, 1'b0), 13'h0123);
    go(mk(1'b0, 2'h0, 2'h2, 1'b1, 1'b0), 13'h0123);
    check(word, exp_word(2'h0, 13'h0123, 1'b1, 1'b0));
    resetn = 1'b0;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(16'(seq_active), 16'h0000);
    check(16'(range_ref), 16'(adc_seq_pkg::CTRL_RESET[1]));
    go(mk(1'b0, 2'h0, 2'h3, 1'b1, 1'b0), 13'h0123);
    check(word, exp_word(2'h0, 13'h0123, 1'b0, 1'b0));
  endtask : t_reset

  // main sequence
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(16'(power_mode), 16'(adc_seq_pkg::CTRL_RESET[5:4]));
    check(16'(seq_active), 16'h0000);
    check(16'(range_ref), 16'(adc_seq_pkg::CTRL_RESET[1]));
    check(16'(mux_chan), 16'(adc_seq_pkg::CHAN_RESET));
    check(16'(dout_oe), 16'h0000);
    t_manual();
    t_sequence();
    t_abort();
    t_power();
    t_reset();
    final_report();
  end

  // watchdog well beyond the 30 or so frames of about 7.2 us each
  initial begin
    #1_000_000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule : tb_adc_seq_ctrl
